// ---- design/sdm_map.vh ----
`ifndef SDM_MAP_VH
`define SDM_MAP_VH
`define SDM_CLK_MHZ 100
`define SDM_BIT_MHZ 10
`define SDM_BIT_DIV (`SDM_CLK_MHZ / `SDM_BIT_MHZ)
`define SDM_CODE_W 17
`define SDM_FS_POS 17'sh08000
`define SDM_FS_NEG -17'sh08000
`define SDM_MID 17'h08000
`define SDM_SPAN 18'h10000
`define SDM_LVL_TOP 17'h10000
`define SDM_FIFO_DEPTH 8
`define SDM_FS_MV 640
`endif

// ---- design/sdm_fifo.v ----
`timescale 1ns/10ps
module sdm_fifo #(
  parameter WIDTH = 17,
  parameter DEPTH = 8
) (
  input wire CLK, // system clock
  input wire RST_N, // async reset, active low
  input wire [WIDTH-1:0] IN_DATA, // write word
  input wire IN_VALID, // write request
  output wire IN_READY, // room for a word
  output reg [WIDTH-1:0] OUT_DATA, // head word
  output wire OUT_VALID, // head word present
  input wire OUT_READY // head word taken
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  integer i;

  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      if (p == DEPTH - 1)
        ptr_inc = {AW{1'b0}};
      else
        ptr_inc = p + 1'b1;
    end
  endfunction

  assign IN_READY = (count != DEPTH);
  assign OUT_VALID = (count != 0);
  assign push = IN_VALID && IN_READY;
  assign pop = OUT_VALID && OUT_READY;

  always @* begin
    OUT_DATA = mem[rd_ptr];
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= IN_DATA;
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop)
        rd_ptr <= ptr_inc(rd_ptr);
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

// ---- design/sdm_top.v ----
`timescale 1ns/10ps
`include "sdm_map.vh"
// Function
// RULE1 - one stream bit per modulator clock period, modulator clock nominally 10 MHz
// RULE2 - average of ones tracks the input value linearly
// RULE3 - ones fraction equals input over 640 mV plus one half
// RULE4 - at or beyond full scale the stream is all ones or all zeros
// RULE5 - receiving filter turns the bit stream into slower multi-bit words
// RULE6 - receiver should use a third-order sinc decimator
// RULE7 - ratio 256, 16-bit words: one word per 256 bits, about 39 kHz
// RULE8 - output words are offset binary, zero at negative full scale
// RULE9 - code is input over 640 mV times 65536 plus 32768
// RULE10 - 18.75 percent ones gives 12288, 81.25 percent gives 53248
// RULE11 - receiver samples data once per modulator clock with that clock
// RULE12 - receiver saturates an all-ones window at the top code
module sdm_top #(
  parameter BIT_DIV = `SDM_BIT_DIV,
  parameter FIFO_DEPTH = `SDM_FIFO_DEPTH
) (
  input wire CLK, // 100 MHz system clock
  input wire RST_N, // async reset, active low
  input wire [`SDM_CODE_W-1:0] IN_CODE, // signed input, 32768 lsb = 320 mV
  input wire IN_VALID, // input word offered
  output wire IN_READY, // input buffer has room
  output reg MCLK, // modulator clock out
  output reg MDAT, // modulator data out
  output reg OVER_RANGE, // last used input was clipped to full scale
  output reg UNDERRUN // no new input word at the last bit tick
);
  // four-bit counter, so the divide ratio must stay at 16 or below
  localparam [3:0] LAST = BIT_DIV[3:0] - 4'h1;
  localparam [3:0] HALF = BIT_DIV[4:1];

  reg [3:0] div_cnt;
  reg [3:0] next_div_cnt;
  reg [`SDM_CODE_W-1:0] cur_code;
  reg [15:0] acc;
  reg [17:0] sum;
  reg [16:0] level;
  wire bit_tick;
  wire [`SDM_CODE_W-1:0] head_code;
  wire head_valid;

  // clip to plus or minus full scale so the stream saturates cleanly
  function [16:0] to_level;
    input [`SDM_CODE_W-1:0] code;
    reg signed [`SDM_CODE_W-1:0] s;
    begin
      s = code;
      if (s > `SDM_FS_POS)
        to_level = `SDM_LVL_TOP;
      else if (s < `SDM_FS_NEG)
        to_level = 17'h00000;
      else
        to_level = code + `SDM_MID;
    end
  endfunction

  function is_clipped;
    input [`SDM_CODE_W-1:0] code;
    reg signed [`SDM_CODE_W-1:0] s;
    begin
      s = code;
      is_clipped = (s > `SDM_FS_POS) || (s < `SDM_FS_NEG);
    end
  endfunction

  assign bit_tick = (div_cnt == LAST); // RULE1

  // the modulator drains one word per bit, so a faster source fills the buffer
  sdm_fifo #(
    .WIDTH(`SDM_CODE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .CLK(CLK),
    .RST_N(RST_N),
    .IN_DATA(IN_CODE),
    .IN_VALID(IN_VALID),
    .IN_READY(IN_READY),
    .OUT_DATA(head_code),
    .OUT_VALID(head_valid),
    .OUT_READY(bit_tick)
  );

  always @* begin
    if (bit_tick)
      next_div_cnt = 4'h0;
    else
      next_div_cnt = div_cnt + 4'h1;
  end

  // first-order accumulator: carry density equals level over span exactly
  always @* begin
    level = to_level(cur_code); // RULE3 RULE4
    sum = {2'b00, acc} + {1'b0, level}; // RULE2
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt <= 4'h0;
      MCLK <= 1'b0;
      MDAT <= 1'b0;
      acc <= 16'h0000;
      cur_code <= {`SDM_CODE_W{1'b0}};
      OVER_RANGE <= 1'b0;
      UNDERRUN <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      // data changes on the falling edge, stable through the rising edge
      MCLK <= (next_div_cnt >= HALF); // RULE1
      if (bit_tick) begin
        if (sum >= `SDM_SPAN) begin
          MDAT <= 1'b1; // RULE3
          acc <= sum[15:0];
        end else begin
          MDAT <= 1'b0;
          acc <= sum[15:0];
        end
        OVER_RANGE <= is_clipped(cur_code); // RULE4
        UNDERRUN <= !head_valid;
        // without a new word the last input is held
        if (head_valid)
          cur_code <= head_code;
      end
    end
  end
endmodule

// ---- bench/sdm_monitor.sv ----
`timescale 1ns/10ps
module sdm_monitor #(
  parameter BIT_DIV = 10,
  parameter FIFO_DEPTH = 8
) (
  input wire CLK, // clock
  input wire RST_N, // reset
  input wire MCLK, // bit clock
  input wire MDAT, // bit data
  input wire OVER_RANGE, // clip flag
  input wire UNDERRUN // empty flag
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_low; !MCLK [*5]; endsequence
  sequence s_high; MCLK [*5]; endsequence
  property p_mclk; $fell(MCLK) |-> s_low ##1 s_high ##1 !MCLK; endproperty
  property p_mdat; $changed(MDAT) |-> $fell(MCLK); endproperty
  property p_ovr; $changed(OVER_RANGE) |-> $fell(MCLK); endproperty
  property p_udr; $changed(UNDERRUN) |-> $fell(MCLK); endproperty
  a_mclk: assert property (p_mclk) else $error("bit clock shape");
  a_mdat: assert property (p_mdat) else $error("data off tick");
  a_ovr: assert property (p_ovr) else $error("clip off tick");
  a_udr: assert property (p_udr) else $error("underrun off tick");
endmodule
bind sdm_top sdm_monitor #(.BIT_DIV(BIT_DIV), .FIFO_DEPTH(FIFO_DEPTH)) mon (.CLK(CLK),
  .RST_N(RST_N), .MCLK(MCLK), .MDAT(MDAT), .OVER_RANGE(OVER_RANGE), .UNDERRUN(UNDERRUN));

// ---- bench/sdm_rx_model.sv ----
`timescale 1ns/10ps
module sdm_rx_model (
  input wire logic clk, // clock
  input wire logic mclk, // bit clock
  input wire logic mdat, // bit data
  input wire logic clr, // restart window
  output logic [15:0] code, // offset binary word
  output logic done // word ready
);
  logic m_q;
  logic [7:0] n;
  logic [1:0] k;
  logic [24:0] i1, i2, i3, d1, d2, d3;
  logic [24:0] a1, a2, a3, c1, c2, c3;
  // sinc3 over 256 bits; sums may wrap, the result always fits 25 bits
  always_comb begin
    a1 = i1 + {24'h000000, mdat};
    a2 = i2 + a1;
    a3 = i3 + a2;
    c1 = a3 - d1;
    c2 = c1 - d2;
    c3 = c2 - d3;
  end
  // third word is the first whose window is filled wholly with bits taken after clr
  always @(posedge clk) begin
    m_q <= mclk;
    if (clr) begin
      n <= 8'h00;
      k <= 2'h0;
      i1 <= 25'h0000000;
      i2 <= 25'h0000000;
      i3 <= 25'h0000000;
      d1 <= 25'h0000000;
      d2 <= 25'h0000000;
      d3 <= 25'h0000000;
      done <= 1'b0;
    end else if (mclk && !m_q && !done) begin
      i1 <= a1;
      i2 <= a2;
      i3 <= a3;
      n <= n + 8'h01;
      if (n == 8'hff) begin
        d1 <= a3;
        d2 <= c1;
        d3 <= c2;
        k <= k + 2'h1;
        if (k == 2'h2) begin
          done <= 1'b1;
          // an all-ones window overflows 16 bits, so pin it at the top
          code <= c3[24] ? 16'hffff : c3[23:8];
        end
      end
    end
  end
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  logic CLK = 0, RST_N = 0, IN_VALID = 0, clr = 1;
  logic [16:0] IN_CODE = 17'h00000;
  wire IN_READY, MCLK, MDAT, OVER_RANGE, UNDERRUN, done;
  wire [15:0] code;
  int miscompares = 0, checked = 0;
  always #5 CLK = ~CLK;
  sdm_top dut (.CLK(CLK), .RST_N(RST_N), .IN_CODE(IN_CODE), .IN_VALID(IN_VALID),
    .IN_READY(IN_READY), .MCLK(MCLK), .MDAT(MDAT), .OVER_RANGE(OVER_RANGE), .UNDERRUN(UNDERRUN));
  sdm_rx_model rx (.clk(CLK), .mclk(MCLK), .mdat(MDAT), .clr(clr), .code(code), .done(done));
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // 200 cycles flushes the eight stale buffered words
  task automatic level(input logic [16:0] c, input logic [15:0] exp, input logic ovr);
    int i;
    IN_CODE <= c;
    repeat (200) @(posedge CLK);
    clr <= 1;
    @(posedge CLK);
    clr <= 0;
    // let the restart land, or a stale done from the last level ends the wait
    @(posedge CLK);
    for (i = 0; i < 8000 && done !== 1'b1; i++) @(posedge CLK);
    cmp("done", 16'h1, {15'h0, done});
    cmp("code", exp, code);
    cmp("over_range", {15'h0, ovr}, {15'h0, OVER_RANGE});
    cmp("underrun", 16'h0, {15'h0, UNDERRUN});
  endtask
  task automatic t_fill;
    // look off a bit tick, where the buffer briefly has room
    repeat (35) @(posedge CLK);
    cmp("in_ready", 16'h0, {15'h0, IN_READY});
    IN_VALID <= 0;
    repeat (150) @(posedge CLK);
    cmp("underrun", 16'h1, {15'h0, UNDERRUN});
    IN_VALID <= 1;
  endtask
  task automatic t_mid; level(17'h00000, 16'h8000, 0); endtask
  task automatic t_rec;
    level(17'h1b000, 16'h3000, 0);
    level(17'h05000, 16'hd000, 0);
  endtask
  task automatic t_fs;
    level(17'h08000, 16'hffff, 0);
    level(17'h18000, 16'h0000, 0);
  endtask
  task automatic t_clip;
    level(17'h09c40, 16'hffff, 1);
    level(17'h163c0, 16'h0000, 1);
  endtask
  // reset in mid-run clears the clip flag left by the last level
  task automatic t_rst;
    RST_N <= 0;
    repeat (2) @(posedge CLK);
    cmp("mclk", 16'h0, {15'h0, MCLK});
    cmp("mdat", 16'h0, {15'h0, MDAT});
    cmp("over_range", 16'h0, {15'h0, OVER_RANGE});
    cmp("in_ready", 16'h1, {15'h0, IN_READY});
    RST_N <= 1;
    repeat (2) @(posedge CLK);
  endtask
  initial begin
    // seven levels of about 7900 cycles each, with margin
    #700000;
    miscompares++;
    conclude;
  end
  initial begin
    repeat (2) @(posedge CLK);
    RST_N <= 1;
    IN_VALID <= 1;
    t_fill;
    t_mid;
    t_rec;
    t_fs;
    t_clip;
    t_rst;
    conclude;
  end
endmodule
